// ### rtl/iosg_alu.sv
// Combinational result and flag logic for the execute block
`default_nettype none
module iosg_alu
  import iosg_pkg::*;
(
  // Operation and operands
  input wire iosg_op_t op,
  input wire logic [iosg_pkg::IOSG_W-1:0] w_val,
  input wire logic [iosg_pkg::IOSG_W-1:0] f_val,
  input wire logic [iosg_pkg::IOSG_W-1:0] lit,
  // Results
  output logic [iosg_pkg::IOSG_W-1:0] result,
  output logic z_new,
  output logic z_upd,
  output logic c_new,
  output logic c_upd
);
  wire logic [IOSG_W-1:0] inc_val;
  wire logic [IOSG_W-1:0] shl_val;
  assign inc_val = f_val + 8'h01;
  assign shl_val = {f_val[IOSG_W-2:0], 1'b0};
  always_comb
  begin
    case (op)
      IOSG_OP_INC, IOSG_OP_INCSZ: result = inc_val;
      IOSG_OP_IORL: result = w_val | lit;
      IOSG_OP_IORF: result = w_val | f_val;
      IOSG_OP_LSL: result = shl_val;
      default: result = 8'h00;
    endcase
  end
  // Skip variant leaves flags alone
  assign z_upd = (op == IOSG_OP_INC) || (op == IOSG_OP_IORL) ||
                 (op == IOSG_OP_IORF) || (op == IOSG_OP_LSL);
  assign z_new = (result == 8'h00);
  assign c_upd = (op == IOSG_OP_LSL);
  assign c_new = f_val[IOSG_W-1];
endmodule // iosg_alu
`default_nettype wire

// ### rtl/iosg_exec.sv
// Execute stage for increment, OR, left shift and absolute branch
`default_nettype none
module iosg_exec
  import iosg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Instruction issue, one per instruction cycle
  input wire logic instr_valid,
  input wire iosg_pkg::iosg_op_t instr_op,
  input wire logic instr_dest,
  input wire logic [iosg_pkg::IOSG_FA_W-1:0] instr_faddr,
  input wire logic [iosg_pkg::IOSG_W-1:0] instr_lit,
  input wire logic [iosg_pkg::IOSG_K11_W-1:0] instr_k11,
  // File register port
  input wire logic [iosg_pkg::IOSG_W-1:0] file_rdata,
  output logic [iosg_pkg::IOSG_FA_W-1:0] file_addr,
  output logic file_we,
  output logic [iosg_pkg::IOSG_W-1:0] file_wdata,
  // Program counter latch from the core
  input wire logic [iosg_pkg::IOSG_LATCH_W-1:0] pc_upper_latch,
  // Architectural state
  output logic [iosg_pkg::IOSG_W-1:0] w_reg,
  output logic z_flag,
  output logic c_flag,
  output logic [iosg_pkg::IOSG_PC_W-1:0] pc_reg,
  // Pipeline control
  output logic stall,
  output logic flush
);
  ////////////////////////////////////////////////////////////////////////////
  logic [IOSG_W-1:0] w_r;
  logic [IOSG_W-1:0] w_nxt;
  logic z_r;
  logic z_nxt;
  logic c_r;
  logic c_nxt;
  logic [IOSG_PC_W-1:0] pc_r;
  logic [IOSG_PC_W-1:0] pc_nxt;
  logic busy_r;
  logic flush_r;
  logic [IOSG_W-1:0] alu_res;
  logic alu_z;
  logic alu_zu;
  logic alu_c;
  logic alu_cu;

  wire logic go;
  wire logic is_file_op;
  wire logic to_file;
  wire logic to_w;
  wire logic is_branch;
  wire logic skip_hit;
  wire logic [IOSG_PC_W-1:0] branch_pc;
  wire iosg_op_t alu_op;
  wire logic op_inc;
  wire logic op_incsz;
  wire logic op_iorl;
  wire logic op_iorf;
  wire logic op_lsl;
  wire logic op_bra;

  iosg_alu u_alu (
    .op(alu_op),
    .w_val(w_r),
    .f_val(file_rdata),
    .lit(instr_lit),
    .result(alu_res),
    .z_new(alu_z),
    .z_upd(alu_zu),
    .c_new(alu_c),
    .c_upd(alu_cu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Second cycle of a branch or the flushed slot executes nothing
  assign go = instr_valid && !busy_r && !flush_r;
  assign is_file_op = (instr_op == IOSG_OP_INC) || (instr_op == IOSG_OP_INCSZ) ||
                      (instr_op == IOSG_OP_IORF) || (instr_op == IOSG_OP_LSL);
  assign to_file = go && is_file_op && (instr_dest == IOSG_DEST_F);
  assign to_w = go && ((is_file_op && (instr_dest == IOSG_DEST_W)) ||
                       (instr_op == IOSG_OP_IORL));
  assign is_branch = go && (instr_op == IOSG_OP_BRA);
  assign skip_hit = go && (instr_op == IOSG_OP_INCSZ) && (alu_res == 8'h00);
  // Upper bits come from latch 6:3, the wider of the two printed forms
  assign branch_pc = {pc_upper_latch[IOSG_LATCH_HI:IOSG_LATCH_LO], instr_k11};

  // Opcode decode shared with the checks below
  assign op_inc = (instr_op == IOSG_OP_INC);
  assign op_incsz = (instr_op == IOSG_OP_INCSZ);
  assign op_iorl = (instr_op == IOSG_OP_IORL);
  assign op_iorf = (instr_op == IOSG_OP_IORF);
  assign op_lsl = (instr_op == IOSG_OP_LSL);
  assign op_bra = (instr_op == IOSG_OP_BRA);
  // Idle code for dropped slots, so they cannot touch flags
  assign alu_op = go ? instr_op : IOSG_OP_NONE;

  assign file_addr = instr_faddr;
  assign file_we = to_file;
  assign file_wdata = alu_res;
  assign w_nxt = to_w ? alu_res : w_r;
  assign z_nxt = (go && alu_zu) ? alu_z : z_r;
  assign c_nxt = (go && alu_cu) ? alu_c : c_r;
  assign pc_nxt = is_branch ? branch_pc :
                  ((instr_valid && !busy_r) ? pc_r + 15'h0001 : pc_r);

  assign w_reg = w_r;
  assign z_flag = z_r;
  assign c_flag = c_r;
  assign pc_reg = pc_r;
  assign stall = busy_r;
  assign flush = flush_r;

  ////////////////////////////////////////////////////////////////////////////
  // One process per register keeps each reset value beside its use
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_r <= IOSG_W_RST;
    end
    else
    begin
      w_r <= w_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      z_r <= IOSG_Z_RST;
    end
    else
    begin
      z_r <= z_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c_r <= IOSG_C_RST;
    end
    else
    begin
      c_r <= c_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_r <= IOSG_PC_RST;
    end
    else
    begin
      pc_r <= pc_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_r <= IOSG_STALL_RST;
    end
    else
    begin
      busy_r <= is_branch;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flush_r <= IOSG_FLUSH_RST;
    end
    else
    begin
      flush_r <= skip_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Destination routing
  dest_file_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && is_file_op && instr_dest == IOSG_DEST_F) |->
      file_we ##1 $stable(w_r))
    else $error("file destination misrouted");
  dest_w_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && is_file_op && instr_dest == IOSG_DEST_W) |->
      !file_we ##1 w_r == $past(file_wdata))
    else $error("accumulator destination misrouted");

  // Skip and its dropped slot
  skip_flush_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && op_incsz && file_rdata == 8'hff) |=>
      flush)
    else $error("skip did not flush");
  skip_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && op_incsz && file_rdata != 8'hff) |=>
      !flush)
    else $error("skip flushed on nonzero result");
  skip_value_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && op_incsz) |->
      file_wdata == file_rdata + 8'h01)
    else $error("skip increment wrong");
  flush_slot_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    flush |->
      !file_we ##1 $stable(w_r) && $stable(z_r) && $stable(c_r))
    else $error("flushed slot executed");
  flush_pc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (flush && instr_valid) |=>
      pc_r == $past(pc_r) + 15'h0001)
    else $error("flushed slot did not step pc");
  skip_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && op_incsz) |=>
      $stable(z_r) && $stable(c_r))
    else $error("skip changed flags");

  // Branch target and timing
  branch_target_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_branch |=>
      pc_r == $past(branch_pc))
    else $error("branch target not loaded");
  branch_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_branch |=>
      pc_r[10:0] == $past(instr_k11))
    else $error("branch low bits wrong");
  branch_upper_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_branch |=>
      pc_r[14:11] == $past(pc_upper_latch[6:3]))
    else $error("branch upper bits wrong");
  branch_two_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    is_branch |=>
      stall ##1 !stall)
    else $error("branch not two cycles");
  stall_slot_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stall |->
      !file_we ##1 $stable(pc_r) && $stable(w_r) && $stable(z_r))
    else $error("stall slot executed");

  // OR operations
  or_lit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && op_iorl) |=>
      w_r == ($past(w_r) | $past(instr_lit)) && z_r == (w_r == 8'h00))
    else $error("or literal wrong");
  or_lit_dest_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && op_iorl) |->
      !file_we)
    else $error("or literal wrote file");
  or_file_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && op_iorf) |->
      file_wdata == (w_r | file_rdata))
    else $error("or file wrong");
  or_file_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && op_iorf) |=>
      z_r == ($past(file_wdata) == 8'h00))
    else $error("or file zero flag wrong");

  // Increment and zero hold
  inc_value_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && op_inc) |->
      file_wdata == file_rdata + 8'h01)
    else $error("increment result wrong");
  inc_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && op_inc) |=>
      z_r == ($past(file_rdata) == 8'hff))
    else $error("increment zero flag wrong");
  zero_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(go && (op_inc || op_iorl || op_iorf || op_lsl)) |=>
      $stable(z_r))
    else $error("zero flag changed without cause");

  // Left shift and carry hold
  shift_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && op_lsl) |->
      file_wdata[0] == 1'b0 ##1 c_r == $past(file_rdata[7]))
    else $error("shift carry wrong");
  shift_value_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && op_lsl) |->
      file_wdata[7:1] == file_rdata[6:0])
    else $error("shift data wrong");
  shift_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (go && op_lsl) |=>
      z_r == ($past(file_wdata) == 8'h00))
    else $error("shift zero flag wrong");
  carry_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(go && op_lsl) |=>
      $stable(c_r))
    else $error("carry changed without shift");

  branch_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    is_branch ##2 go);
  skip_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    skip_hit);
  shift_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    go && op_lsl && file_rdata[7]);
  dest_w_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    go && is_file_op && instr_dest == IOSG_DEST_W);
  flush_drop_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    flush && instr_valid && op_iorl);
endmodule // iosg_exec
`default_nettype wire

// ### rtl/iosg_pkg.sv
// Package of opcodes, field layouts and reset values for the execute block
`default_nettype none
package iosg_pkg;
  localparam int IOSG_W = 8;
  localparam int IOSG_FA_W = 7;
  localparam int IOSG_PC_W = 15;
  localparam int IOSG_K11_W = 11;
  localparam int IOSG_LATCH_W = 7;
  localparam int IOSG_LATCH_LO = 3;
  localparam int IOSG_LATCH_HI = 6;
  localparam logic [IOSG_W-1:0] IOSG_W_RST = 8'h00;
  localparam logic [IOSG_PC_W-1:0] IOSG_PC_RST = 15'h0000;
  localparam logic IOSG_Z_RST = 1'b0;
  localparam logic IOSG_C_RST = 1'b0;
  localparam logic IOSG_STALL_RST = 1'b0;
  localparam logic IOSG_FLUSH_RST = 1'b0;
  localparam logic IOSG_DEST_W = 1'b0;
  localparam logic IOSG_DEST_F = 1'b1;
  // Operation select presented by the fetch/decode stage
  typedef enum logic [2:0] {
    IOSG_OP_NONE = 3'h0,
    IOSG_OP_INC = 3'h1,
    IOSG_OP_INCSZ = 3'h2,
    IOSG_OP_IORL = 3'h3,
    IOSG_OP_IORF = 3'h4,
    IOSG_OP_LSL = 3'h5,
    IOSG_OP_BRA = 3'h6
  } iosg_op_t;
endpackage : iosg_pkg
`default_nettype wire

// ### testbench/tb_incr_or_shift_absolute_branch_op_exec.sv
// Self-checking bench for the execute block
`default_nettype none
module tb_incr_or_shift_absolute_branch_op_exec
  import iosg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {iosg_op_t op; logic d; logic [7:0] rd, lit; logic we;
    logic [7:0] res, w; logic z, c;} iosg_row_t;
  logic ref_clk, rst_n, instr_valid, instr_dest, file_we, z_flag, c_flag, stall, flush;
  iosg_op_t instr_op;
  logic [6:0] instr_faddr, file_addr, pc_upper_latch;
  logic [7:0] instr_lit, file_rdata, file_wdata, w_reg;
  logic [10:0] instr_k11;
  logic [14:0] pc_reg, pc_e;
  int n_fail = 0;
  int compares = 0;
  // Rows chain: each starts from the state the previous one left
  iosg_row_t rows [10] = '{
    '{IOSG_OP_IORL, 0, 8'h00, 8'h00, 0, 8'h00, 8'h00, 1, 0},
    '{IOSG_OP_IORL, 0, 8'h00, 8'h5a, 0, 8'h00, 8'h5a, 0, 0},
    '{IOSG_OP_INC, 0, 8'hff, 8'h00, 0, 8'h00, 8'h00, 1, 0},
    '{IOSG_OP_INC, 1, 8'h7f, 8'h00, 1, 8'h80, 8'h00, 0, 0},
    '{IOSG_OP_IORF, 0, 8'h81, 8'h00, 0, 8'h00, 8'h81, 0, 0},
    '{IOSG_OP_IORF, 1, 8'h00, 8'h00, 1, 8'h81, 8'h81, 0, 0},
    '{IOSG_OP_LSL, 0, 8'h81, 8'h00, 0, 8'h00, 8'h02, 0, 1},
    '{IOSG_OP_LSL, 1, 8'h80, 8'h00, 1, 8'h00, 8'h02, 1, 1},
    '{IOSG_OP_LSL, 1, 8'h00, 8'h00, 1, 8'h00, 8'h02, 1, 0},
    '{IOSG_OP_INCSZ, 0, 8'h10, 8'h00, 0, 8'h00, 8'h11, 1, 0}};
  iosg_exec dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_dest(instr_dest), .instr_faddr(instr_faddr),
    .instr_lit(instr_lit), .instr_k11(instr_k11), .file_rdata(file_rdata),
    .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
    .pc_upper_latch(pc_upper_latch), .w_reg(w_reg), .z_flag(z_flag), .c_flag(c_flag),
    .pc_reg(pc_reg), .stall(stall), .flush(flush));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [14:0] g, input logic [14:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Inputs land 1 ns after an edge; combinational outputs settle by 7 ns
  task automatic go(input iosg_op_t op, input logic d, input logic [7:0] rd, input logic [7:0] l);
    instr_op = op;
    instr_dest = d;
    file_rdata = rd;
    instr_lit = l;
    #7;
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #5000;
    n_fail++;
    wrap_up();
  end
  initial
  begin
    rst_n = 1'b0;
    instr_valid = 1'b1;
    instr_op = IOSG_OP_NONE;
    {instr_dest, instr_faddr, instr_lit, instr_k11, file_rdata} = '0;
    pc_upper_latch = 7'h5a;
    pc_e = 15'h0000;
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      instr_faddr = 7'h7f - 7'(i);
      go(rows[i].op, rows[i].d, rows[i].rd, rows[i].lit);
      chk(15'(file_addr), 15'(instr_faddr));
      chk(15'(file_we), 15'(rows[i].we));
      if (rows[i].we) chk(15'(file_wdata), 15'(rows[i].res));
      tick();
      pc_e++;
      chk(15'(w_reg), 15'(rows[i].w));
      chk(15'(z_flag), 15'(rows[i].z));
      chk(15'(c_flag), 15'(rows[i].c));
      chk(pc_reg, pc_e);
      chk(15'(flush), 15'h0000);
    end
    go(IOSG_OP_INCSZ, 1'b1, 8'hff, 8'h00);
    chk(15'({file_we, file_wdata}), 15'h0100);
    tick();
    chk(15'({flush, z_flag, c_flag, w_reg}), 15'h0611);
    // Slot after a skip hit is dropped but still consumes a pc step
    go(IOSG_OP_IORL, 1'b0, 8'h00, 8'hff);
    tick();
    chk(15'({flush, w_reg}), 15'h0011);
    chk(pc_reg, pc_e + 15'h0002);
    instr_k11 = 11'h7ff;
    go(IOSG_OP_BRA, 1'b0, 8'h00, 8'h00);
    tick();
    chk(15'(stall), 15'h0001);
    chk(pc_reg, 15'h5fff);
    go(IOSG_OP_IORL, 1'b0, 8'h00, 8'hff);
    tick();
    chk(15'({stall, w_reg}), 15'h0011);
    chk(pc_reg, 15'h5fff);
    go(IOSG_OP_IORL, 1'b0, 8'h00, 8'h00);
    tick();
    chk(15'({z_flag, w_reg}), 15'h0011);
    chk(pc_reg, 15'h6000);
    // Idle code: no write, no state change, pc still steps
    go(IOSG_OP_NONE, 1'b1, 8'h00, 8'h00);
    chk(15'(file_we), 15'h0000);
    tick();
    chk(15'({z_flag, w_reg}), 15'h0011);
    chk(pc_reg, 15'h6001);
    // Asynchronous reset in mid-run, landing in a branch stall slot
    go(IOSG_OP_BRA, 1'b0, 8'h00, 8'h00);
    tick();
    chk(15'(stall), 15'h0001);
    rst_n = 1'b0;
    #2;
    chk(15'({stall, flush, z_flag, c_flag, w_reg}), 15'h0000);
    chk(pc_reg, 15'h0000);
    tick();
    rst_n = 1'b1;
    go(IOSG_OP_IORL, 1'b0, 8'h00, 8'h3c);
    tick();
    chk(15'({stall, z_flag, w_reg}), 15'h003c);
    chk(pc_reg, 15'h0001);
    wrap_up();
  end
endmodule // tb_incr_or_shift_absolute_branch_op_exec
`default_nettype wire
